//--- rtl/flash_ctrl_pkg.sv
package flash_ctrl_pkg;

   // ----------------------------------------------------------------
   // timing of the internal flash clock
   // ----------------------------------------------------------------
   localparam int BUS_PERIOD_NS = 40;     // 25 MHz bus clock
   localparam int PULSE_MIN_NS = 5000;    // shortest program/erase pulse
   localparam int PULSE_MAX_NS = 6700;    // longest program/erase pulse
   // least time rounds up, longest time rounds down
   localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + BUS_PERIOD_NS - 1) / BUS_PERIOD_NS;
   localparam int PULSE_MAX_CYC = PULSE_MAX_NS / BUS_PERIOD_NS;
   localparam int PRESCALE_RATIO = 8;     // divide-by-eight prescaler

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'h00;
   localparam logic [7:0] ADDR_OPTION_COPY = 8'h04;
   localparam logic [7:0] ADDR_CONFIG = 8'h08;
   localparam logic [7:0] ADDR_PROTECTION = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [2:0] KEY_BASE_TOP = 3'h1;   // key slots at 0x20..0x3C

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int DIVISOR_LOADED_FLAG_BIT = 7;
   localparam int PRESCALE_BIT = 6;
   localparam int DIVISOR_W = 6;
   localparam int BACKDOOR_KEY_ENABLE_BIT = 7;
   localparam int NORED_BIT = 6;
   localparam int KEY_ACCESS_ENABLE_BIT = 5;
   localparam logic [7:0] OPTION_MASK = 8'hC3;
   localparam logic [1:0] SEC_UNSECURED = 2'h2;
   localparam logic [5:0] DIVISOR_RESET = 6'h00;
   localparam int ST_SECURE_BIT = 0;
   localparam int ST_DIVISOR_LOADED_FLAG_BIT = 1;
   localparam int ST_RANGE_BIT = 2;
   localparam int ST_KEY_ACCESS_ENABLE_BIT = 3;

   // classic wishbone request as seen by the slave
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_s;

   // true for the eight word-aligned key comparison slots
   function automatic logic is_key_addr(input logic [7:0] adr);
      return (adr[7:5] == KEY_BASE_TOP) && (adr[1:0] == 2'h0);
   endfunction

endpackage

//--- rtl/internal_flash_clock_divider.sv
`timescale 1ns/100ps
module internal_flash_clock_divider
   import flash_ctrl_pkg::*;
#(
   parameter int DIV_W = 6
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic prescale_i,
   input wire logic [DIV_W-1:0] divisor_i,
   output logic tick_o
);

   // ----------------------------------------------------------------
   // prescaler and main divider
   // ----------------------------------------------------------------
   logic [2:0] pre_cnt;       // bus cycles within one prescaled step
   logic [DIV_W-1:0] div_cnt; // steps within one flash clock period
   logic step;                // divider input enable

   // input is the bus clock or the bus clock over eight
   assign step = prescale_i ? (pre_cnt == 3'(PRESCALE_RATIO - 1)) : 1'b1;

   // prescaler free-runs only while the divider is allowed to run
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         pre_cnt <= 3'h0;
      end else begin
         pre_cnt <= pre_cnt + 3'h1;
      end
   end

   // one tick every divisor+1 steps, one bus cycle wide
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         div_cnt <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (step) begin
            if (div_cnt >= divisor_i) begin
               div_cnt <= '0;
               tick_o <= 1'b1;
            end else begin
               div_cnt <= div_cnt + 1'b1;
            end
         end
      end
   end

endmodule

//--- rtl/key_compare.sv
`timescale 1ns/100ps
module key_compare
   import flash_ctrl_pkg::*;
#(
   parameter int KEY_BYTES = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic open_i,
   input wire logic write_i,
   input wire logic [$clog2(KEY_BYTES)-1:0] index_i,
   input wire logic [7:0] byte_i,
   input wire logic close_i,
   input wire logic [KEY_BYTES*8-1:0] stored_key_i,
   output logic match_o
);

   localparam int IDX_W = $clog2(KEY_BYTES);

   // ----------------------------------------------------------------
   // entered key and order tracking
   // ----------------------------------------------------------------
   logic [7:0] entered [KEY_BYTES];   // bytes written during the session
   logic [IDX_W:0] next_slot;         // slot expected next
   logic in_order;                    // every write hit the expected slot
   logic [KEY_BYTES-1:0] byte_eq;     // per-byte equality

   // compare every entered byte against its stored twin
   for (genvar g = 0; g < KEY_BYTES; g++) begin : g_cmp
      assign byte_eq[g] = (entered[g] == stored_key_i[g*8 +: 8]);
   end

   // storage is written by slot index
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < KEY_BYTES; i++) begin
            entered[i] <= 8'h00;
         end
      end else if (write_i) begin
         entered[index_i] <= byte_i;
      end
   end

   // ascending order, one write per slot, nothing beyond the last
   always_ff @(posedge clk_i) begin
      if (rst_i || open_i) begin
         next_slot <= '0;
         in_order <= 1'b1;
      end else if (write_i) begin
         if (next_slot == (IDX_W+1)'(KEY_BYTES) || index_i != next_slot[IDX_W-1:0]) begin
            in_order <= 1'b0;
         end
         if (next_slot != (IDX_W+1)'(KEY_BYTES)) begin
            next_slot <= next_slot + 1'b1;
         end
      end
   end

   // verdict given once, on the closing write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_o <= 1'b0;
      end else begin
         match_o <= close_i && in_order && (next_slot == (IDX_W+1)'(KEY_BYTES))
                    && (&byte_eq);
      end
   end

endmodule

//--- rtl/flash_clock_security_ctrl.sv
`timescale 1ns/100ps
// What this block does
// - divisor-loaded flag: reset clears, first write sets
// - no program or erase until flag set
// - prescale bit selects bus clock or over eight
// - flash clock is input over divisor plus one
// - timing pulse is one flash clock cycle
// - option and protection bytes loaded at reset
// - key enable zero forbids backdoor unlock
// - matching ordered eight-byte key unlocks until reset
// - key writes only from secured firmware
// - redirection-disable bit gates vector redirection
// - only code 1:0 means unsecured
// - secure device blocks unsecured memory access
// - key match or blank check unsecures
// - key-access bit steers key location writes
// - clearing key-access bit triggers key comparison
module flash_clock_security_ctrl
   import flash_ctrl_pkg::*;
#(
   parameter int KEY_BYTES = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire wb_req_s wb_req_i,                    // wishbone request
   output logic [31:0] wb_dat_o,                     // read data
   output logic wb_ack_o,                            // cycle acknowledge
   input wire logic [7:0] nonvolatile_option_byte_i,
   input wire logic [7:0] nonvolatile_protection_byte_i,
   input wire logic [KEY_BYTES*8-1:0] stored_backdoor_key_i,
   input wire logic secure_source_i,                 // master runs from secure memory
   input wire logic blank_check_pass_i,              // whole array found erased
   output logic program_erase_enable_o,
   output logic internal_flash_clock_o,              // one-cycle timing pulse
   output logic command_start_o,                     // key-slot write starts a command
   output logic [2:0] command_index_o,
   output logic [7:0] command_data_o,
   output logic access_error_o,                      // command refused
   output logic redirection_enable_o,
   output logic secure_o,                            // block unsecured access
   output logic [7:0] working_protection_register_o
);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic divisor_loaded_flag;        // divider written since reset
   logic prescale_by_eight;          // prescaler select
   logic [DIVISOR_W-1:0] divisor;    // divisor field
   logic backdoor_key_enable;        // option copy bit 7
   logic redirection_disable;        // option copy bit 6
   logic [1:0] security_code;        // working security code
   logic key_access_enable;          // config key-access bit
   logic key_match;                  // comparator verdict pulse

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic access;                     // new request not yet answered
   logic wr;                         // write on the low byte lane
   logic key_wr;                     // write to a key slot
   logic cfg_wr;                     // write to the config register
   logic next_key_access;            // key-access bit being written
   logic [9:0] internal_flash_clock_period;          // bus cycles per flash clock
   logic clock_in_range;             // settings land inside pulse limits
   logic [7:0] read_byte;            // selected register

   assign access = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   assign wr = access && wb_req_i.we && wb_req_i.sel[0];
   assign key_wr = wr && is_key_addr(wb_req_i.adr);
   assign cfg_wr = wr && (wb_req_i.adr == ADDR_CONFIG);
   assign next_key_access = wb_req_i.dat[KEY_ACCESS_ENABLE_BIT];

   // period held against the pulse limits; the status range bit lets software check its own choice
   always_comb begin
      internal_flash_clock_period = 10'(divisor) + 10'h001;
      if (prescale_by_eight) begin
         internal_flash_clock_period = 10'(internal_flash_clock_period * 10'(PRESCALE_RATIO));
      end
      clock_in_range = (internal_flash_clock_period >= 10'(PULSE_MIN_CYC))
                       && (internal_flash_clock_period <= 10'(PULSE_MAX_CYC));
   end

   // ----------------------------------------------------------------
   // wishbone answer
   // ----------------------------------------------------------------
   // every access, mapped or not, is answered one cycle after it is seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= access;
      end
   end

   // read mux; unmapped addresses and reserved bits read zero
   always_comb begin
      read_byte = 8'h00;
      unique case (wb_req_i.adr)
         ADDR_CLOCK_DIVIDER: begin
            read_byte = {divisor_loaded_flag, prescale_by_eight, divisor};
         end
         ADDR_OPTION_COPY: begin
            read_byte = {backdoor_key_enable, redirection_disable, 4'h0,
                         security_code} & OPTION_MASK;
         end
         ADDR_CONFIG: begin
            read_byte[KEY_ACCESS_ENABLE_BIT] = key_access_enable;
         end
         ADDR_PROTECTION: begin
            read_byte = working_protection_register_o;
         end
         ADDR_STATUS: begin
            read_byte[ST_SECURE_BIT] = security_code != SEC_UNSECURED;
            read_byte[ST_DIVISOR_LOADED_FLAG_BIT] = divisor_loaded_flag;
            read_byte[ST_RANGE_BIT] = clock_in_range;
            read_byte[ST_KEY_ACCESS_ENABLE_BIT] = key_access_enable;
         end
         default: begin
            read_byte = 8'h00;
         end
      endcase
   end

   // read data held with the acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (access) begin
         wb_dat_o <= {24'h00_0000, read_byte};
      end
   end

   // ----------------------------------------------------------------
   // clock divider register
   // ----------------------------------------------------------------
   // any write loads the fields and sets the flag; flag bit is ignored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         divisor_loaded_flag <= 1'b0;
         prescale_by_eight <= 1'b0;
         divisor <= DIVISOR_RESET;
      end else if (wr && wb_req_i.adr == ADDR_CLOCK_DIVIDER) begin
         divisor_loaded_flag <= 1'b1;
         prescale_by_eight <= wb_req_i.dat[PRESCALE_BIT];
         divisor <= wb_req_i.dat[DIVISOR_W-1:0];
      end
   end

   // divider is held idle until software has set it up
   internal_flash_clock_divider #(
      .DIV_W(DIVISOR_W)
   ) u_divider (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(divisor_loaded_flag),
      .prescale_i(prescale_by_eight),
      .divisor_i(divisor),
      .tick_o(internal_flash_clock_o)
   );

   // ----------------------------------------------------------------
   // option and protection copies
   // ----------------------------------------------------------------
   // loaded only by reset; bus writes never reach them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         backdoor_key_enable <= nonvolatile_option_byte_i[BACKDOOR_KEY_ENABLE_BIT];
         redirection_disable <= nonvolatile_option_byte_i[NORED_BIT];
         working_protection_register_o <= nonvolatile_protection_byte_i;
      end
   end

   // working code: hardware may only move it to unsecured
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         security_code <= nonvolatile_option_byte_i[1:0];
      end else if ((key_match && backdoor_key_enable) || blank_check_pass_i) begin
         security_code <= SEC_UNSECURED;
      end
   end

   // ----------------------------------------------------------------
   // config register and key session
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_access_enable <= 1'b0;
      end else if (cfg_wr) begin
         key_access_enable <= next_key_access;
      end
   end

   // only secured firmware may feed the comparator
   key_compare #(
      .KEY_BYTES(KEY_BYTES)
   ) u_key (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .open_i(cfg_wr && next_key_access && !key_access_enable),
      .write_i(key_wr && key_access_enable && secure_source_i),
      .index_i(wb_req_i.adr[4:2]),
      .byte_i(wb_req_i.dat[7:0]),
      .close_i(cfg_wr && !next_key_access && key_access_enable),
      .stored_key_i(stored_backdoor_key_i),
      .match_o(key_match)
   );

   // ----------------------------------------------------------------
   // command launch from key slots
   // ----------------------------------------------------------------
   // with key access off, a key-slot write is the first step of a command
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         command_start_o <= 1'b0;
         access_error_o <= 1'b0;
         command_index_o <= 3'h0;
         command_data_o <= 8'h00;
      end else begin
         command_start_o <= 1'b0;
         access_error_o <= 1'b0;
         if (key_wr && !key_access_enable) begin
            command_index_o <= wb_req_i.adr[4:2];
            command_data_o <= wb_req_i.dat[7:0];
            // refused, not queued, while the divider is unset
            command_start_o <= divisor_loaded_flag;
            access_error_o <= !divisor_loaded_flag;
         end
      end
   end

   // ----------------------------------------------------------------
   // registered status outputs
   // ----------------------------------------------------------------
   // one cycle behind their sources so every output leaves a flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         program_erase_enable_o <= 1'b0;
         redirection_enable_o <= 1'b0;
         secure_o <= 1'b1;
      end else begin
         program_erase_enable_o <= divisor_loaded_flag;
         redirection_enable_o <= !redirection_disable;
         secure_o <= security_code != SEC_UNSECURED;
      end
   end

endmodule

//--- tb/flash_ctrl_monitor.sv
`timescale 1ns/100ps
module flash_ctrl_monitor
   import flash_ctrl_pkg::*;
#(
   parameter int KEY_BYTES = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire wb_req_s wb_req_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [7:0] nonvolatile_option_byte_i,
   input wire logic [7:0] nonvolatile_protection_byte_i,
   input wire logic [KEY_BYTES*8-1:0] stored_backdoor_key_i,
   input wire logic secure_source_i,
   input wire logic blank_check_pass_i,
   input wire logic program_erase_enable_o,
   input wire logic internal_flash_clock_o,
   input wire logic command_start_o,
   input wire logic [2:0] command_index_o,
   input wire logic [7:0] command_data_o,
   input wire logic access_error_o,
   input wire logic redirection_enable_o,
   input wire logic secure_o,
   input wire logic [7:0] working_protection_register_o
);
   // ----------------------------------------------------------------
   // one clock domain, so one default clock and reset guard
   // ----------------------------------------------------------------
   default clocking mon_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_answer_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");
   upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read data bits not zero");

   // ----------------------------------------------------------------
   // divisor-loaded flag and what it gates
   // ----------------------------------------------------------------
   flag_cause_a: assert property ($rose(program_erase_enable_o) |->
      $past(wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0]
      && wb_req_i.adr == ADDR_CLOCK_DIVIDER))
      else $error("enable rose without a divider write");
   flag_holds_a: assert property (program_erase_enable_o |=> program_erase_enable_o)
      else $error("enable dropped without reset");
   start_needs_flag_a: assert property (command_start_o |-> program_erase_enable_o)
      else $error("command started while divider unloaded");
   error_needs_clear_a: assert property (access_error_o |-> !program_erase_enable_o)
      else $error("command refused while divider loaded");
   start_source_a: assert property (command_start_o |-> is_key_addr($past(wb_req_i.adr))
      && command_index_o == $past(wb_req_i.adr[4:2])
      && command_data_o == $past(wb_req_i.dat[7:0]))
      else $error("command start does not match the key slot write");

   // ----------------------------------------------------------------
   // copies loaded at reset and the security state
   // ----------------------------------------------------------------
   prot_stable_a: assert property (!$past(rst_i) |-> $stable(working_protection_register_o))
      else $error("protection copy changed outside reset");
   redir_holds_a: assert property (redirection_enable_o |=> redirection_enable_o)
      else $error("redirection changed outside reset");
   unlock_holds_a: assert property (!secure_o |=> !secure_o)
      else $error("security re-engaged without reset");
   blank_unlocks_a: assert property (blank_check_pass_i && !$past(rst_i) |=> ##1 !secure_o)
      else $error("blank check pass did not unsecure");
endmodule

bind flash_clock_security_ctrl flash_ctrl_monitor #(.KEY_BYTES(KEY_BYTES)) mon (
   .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .nonvolatile_option_byte_i(nonvolatile_option_byte_i),
   .nonvolatile_protection_byte_i(nonvolatile_protection_byte_i),
   .stored_backdoor_key_i(stored_backdoor_key_i), .secure_source_i(secure_source_i),
   .blank_check_pass_i(blank_check_pass_i), .program_erase_enable_o(program_erase_enable_o),
   .internal_flash_clock_o(internal_flash_clock_o), .command_start_o(command_start_o),
   .command_index_o(command_index_o), .command_data_o(command_data_o),
   .access_error_o(access_error_o), .redirection_enable_o(redirection_enable_o),
   .secure_o(secure_o), .working_protection_register_o(working_protection_register_o));

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
   import flash_ctrl_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam logic [63:0] KEY = 64'h8877665544332211; // slot 0 in the low byte
   logic clk_i, rst_i, secure_source, blank_pass, pe, internal_flash_clock, start, err, redir, secure;
   wb_req_s req; // request driven by the bus tasks
   logic [31:0] wb_dat_o, rd;
   logic wb_ack_o, seen_start, seen_err; // pulses caught at the ack edge
   logic [7:0] nv_opt, nv_prot, cmd_data, prot;
   logic [2:0] cmd_idx;
   int mismatches, n_checks, cycles;

   flash_clock_security_ctrl #(.KEY_BYTES(8)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .nonvolatile_option_byte_i(nv_opt), .nonvolatile_protection_byte_i(nv_prot),
      .stored_backdoor_key_i(KEY), .secure_source_i(secure_source),
      .blank_check_pass_i(blank_pass), .program_erase_enable_o(pe),
      .internal_flash_clock_o(internal_flash_clock), .command_start_o(start), .command_index_o(cmd_idx),
      .command_data_o(cmd_data), .access_error_o(err), .redirection_enable_o(redir),
      .secure_o(secure), .working_protection_register_o(prot));

   // ----------------------------------------------------------------
   // clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // the whole run needs several hundred cycles, so this only trips on a hang
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one classic cycle; no fixed latency assumed, the watchdog ends a hang
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: {24'h000000, d}};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      seen_start = start;
      seen_err = err;
      req <= '0;
   endtask

   // nonvolatile option byte is sampled while reset is held
   task automatic do_reset(input logic [7:0] opt);
      @(posedge clk_i);
      rst_i <= 1'b1;
      nv_opt <= opt;
      nv_prot <= ~opt;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   // open, eight ascending slot writes, close; then let the verdict land
   task automatic key_session(input logic src);
      bus(1'b1, ADDR_CONFIG, 8'h20);
      secure_source <= src;
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, 8'h20 + 8'(4 * k), KEY[8*k +: 8]);
         check("no_command_in_session", seen_start, 1'b0);
      end
      bus(1'b1, ADDR_CONFIG, 8'h00);
      repeat (4) @(posedge clk_i);
   endtask

   // edges between two flash clock pulses
   task automatic internal_flash_clock_period(input int exp);
      int n;
      n = 0;
      while (internal_flash_clock !== 1'b1 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      @(posedge clk_i);
      n = 1;
      while (internal_flash_clock !== 1'b1 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      check("internal_flash_clock_period", n, exp);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_state;
      do_reset(8'hC1);
      check("secure", secure, 1'b1);
      check("redirection", redir, 1'b0);
      check("protection", prot, 8'h3E);
      check("pe_enable", pe, 1'b0);
      bus(1'b0, ADDR_OPTION_COPY, 8'h00);
      check("option", rd, 32'h000000C1);
      // new nonvolatile bytes must not reach the copies before a reset
      nv_opt <= 8'h02;
      nv_prot <= 8'h00;
      bus(1'b1, ADDR_OPTION_COPY, 8'h00);
      bus(1'b0, ADDR_OPTION_COPY, 8'h00);
      check("option_wr", rd, 32'h000000C1);
      check("protection_hold", prot, 8'h3E);
      check("secure_hold", secure, 1'b1);
      bus(1'b0, ADDR_CLOCK_DIVIDER, 8'h00);
      check("divider", rd, 32'h00000000);
      bus(1'b1, ADDR_CONFIG, 8'hFF);
      bus(1'b0, ADDR_CONFIG, 8'h00);
      check("config", rd, 32'h00000020);
      bus(1'b1, ADDR_CONFIG, 8'h00);
      bus(1'b0, 8'hFC, 8'h00);
      check("unmapped", rd, 32'h00000000);
      for (int c = 0; c < 4; c++) begin
         do_reset(8'(c));
         check("code", secure, logic'(c != 2));
      end
      $display("test reset_state done");
   endtask

   task automatic t_commands;
      bus(1'b1, 8'h24, 8'h5A);
      check("refused", {seen_err, seen_start}, 2'b10);
      bus(1'b1, ADDR_CLOCK_DIVIDER, 8'h03);
      @(posedge clk_i);
      check("pe_enable", pe, 1'b1);
      bus(1'b0, ADDR_CLOCK_DIVIDER, 8'h00);
      check("divider", rd, 32'h00000083);
      bus(1'b1, ADDR_CLOCK_DIVIDER, 8'h45);
      bus(1'b0, ADDR_CLOCK_DIVIDER, 8'h00);
      check("divider2", rd, 32'h000000C5);
      bus(1'b1, 8'h3C, 8'hA5);
      check("started", {seen_err, seen_start}, 2'b01);
      check("cmd_index", cmd_idx, 3'h7);
      check("cmd_data", cmd_data, 8'hA5);
      $display("test commands done");
   endtask

   task automatic t_flash_clock;
      bus(1'b1, ADDR_CLOCK_DIVIDER, 8'h03);
      internal_flash_clock_period(4);
      // status: secure code, flag set, clock far too fast, key access off
      bus(1'b0, ADDR_STATUS, 8'h00);
      check("status_fast", rd, 32'h00000003);
      bus(1'b1, ADDR_CLOCK_DIVIDER, 8'h05);
      internal_flash_clock_period(6);
      bus(1'b1, ADDR_CLOCK_DIVIDER, 8'h41);
      internal_flash_clock_period(16);
      // 128 bus cycles per pulse keeps the flash clock inside its band
      bus(1'b1, ADDR_CLOCK_DIVIDER, 8'h4F);
      internal_flash_clock_period(128);
      bus(1'b0, ADDR_STATUS, 8'h00);
      check("status_band", rd, 32'h00000007);
      $display("test flash_clock done");
   endtask

   task automatic t_keys;
      do_reset(8'h80);
      check("redirection", redir, 1'b1);
      key_session(1'b1);
      check("unlocked", secure, 1'b0);
      bus(1'b0, ADDR_OPTION_COPY, 8'h00);
      check("option_code", rd, 32'h00000082);
      do_reset(8'h00);
      key_session(1'b1);
      check("key_disabled", secure, 1'b1);
      do_reset(8'h80);
      key_session(1'b0);
      check("unsecured_src", secure, 1'b1);
      @(posedge clk_i);
      blank_pass <= 1'b1;
      @(posedge clk_i);
      blank_pass <= 1'b0;
      repeat (2) @(posedge clk_i);
      check("blank_unlock", secure, 1'b0);
      $display("test keys done");
   endtask

   // ----------------------------------------------------------------
   // verdict and main sequence
   // ----------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      rst_i = 1'b1;
      req = '0;
      nv_opt = 8'h00;
      nv_prot = 8'h00;
      secure_source = 1'b1;
      blank_pass = 1'b0;
      t_reset_state();
      t_commands();
      t_flash_clock();
      t_keys();
      end_of_test();
   end
endmodule
